// ---- logic/sdpa_cfg.svh ----
`ifndef SDPA_CFG_SVH
`define SDPA_CFG_SVH

// ==========================================================================
// Host ports and link
// ==========================================================================
`define SDPA_PORTS 4
`define SDPA_RES_DISK 0
`define SDPA_RES_PRN 1
`define SDPA_STAT_BIT 7

// ==========================================================================
// Device numbers inside the unit's I/O window
// ==========================================================================
`define SDPA_OFS_DISK_STATUS 10'h280
`define SDPA_OFS_DISK_TRACK 10'h282
`define SDPA_OFS_DISK_SECTOR 10'h284
`define SDPA_OFS_DISK_DATA 10'h286
`define SDPA_OFS_DRIVE_CTRL 10'h288
`define SDPA_OFS_PRN_DATA 10'h28A
`define SDPA_OFS_PRN_CTRL 10'h28C
`define SDPA_OFS_DISK_SET 10'h28E
`define SDPA_OFS_DISK_CLR 10'h290
`define SDPA_OFS_PRN_SET 10'h292
`define SDPA_OFS_PRN_CLR 10'h294

// ==========================================================================
// Reset values and timing
// ==========================================================================
`define SDPA_RING_RST 4'h1
`define SDPA_DRVCTL_RST 8'h00
`define SDPA_CLK_NS 10
`define SDPA_PRECOMP_NS 150
`define SDPA_PRECOMP_CYC ((`SDPA_PRECOMP_NS + `SDPA_CLK_NS - 1) / `SDPA_CLK_NS)

`endif

// ---- logic/sdpa_pkg.sv ----
// ==========================================================================
// Shared types
// ==========================================================================
package sdpa_pkg;

  // Address captured in the address phase
  typedef struct packed {
    logic window;
    logic [6:0] addr;
  } sdpa_addr_s;

  // Drive control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic ready_override;
    logic unused6;
    logic density_select;
    logic unused4;
    logic precomp_en;
    logic motor1;
    logic motor0;
    logic drive_sel;
  } sdpa_drvctl_s;

endpackage

// ---- logic/sdpa_arbiter.sv ----
`timescale 1ns/100ps
`include "sdpa_cfg.svh"
// ==========================================================================
// Overview of operation
// [RULE1] Four host ports, each with disk/printer claims
// [RULE2] Free resource goes to the claiming host
// [RULE3] Host releases by clearing its claim flag
// [RULE4] Lamps show current disk and printer owners
// [RULE5] Shared 8-bit multiplexed address/data link
// [RULE6] Latch strobe captures select and A1-A7
// [RULE7] Per-port host reset clears port interface
// [RULE8] Per port: disk irq, printer irq, DMA
// [RULE9] Host or unit reset clears claim flags
// [RULE10] Write 28E sets, 290 clears disk claim
// [RULE11] Write 292 sets, 294 clears printer claim
// [RULE12] Read 28E: bit7 low when disk granted
// [RULE13] Read 292: bit7 low when printer granted
// [RULE14] Resource drivers enabled only for granted port
// [RULE15] Two independent four-position scanning arbiters
// [RULE16] Scan stops on set flag, grants port
// [RULE17] Grant held until flag clears, then rescan
// [RULE18] Disk register decode 280 to 288
// [RULE19] Bit0 picks drive; selected only motor on
// [RULE20] Bits 1,2 switch motors; 4,6 unused
// [RULE21] Bit3 enables 150 ns write precompensation
// [RULE22] Bit5 density; bit7 forces ready true
// [RULE23] Select qualifies only the 280-2FE window
// [RULE24] Idle scan advances one port per clock
module sdpa_arbiter
  import sdpa_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [3:0] host_reset,
  input wire logic [3:0][7:0] host_link_bus_in,
  output logic [3:0][7:0] host_link_bus_out,
  output logic [3:0] host_link_bus_oe,
  input wire logic [3:0] link_addr_latch_strobe,
  input wire logic [3:0] peripheral_select_n,
  input wire logic [3:0] link_read_strobe,
  input wire logic [3:0] link_write_strobe,
  output logic [3:0] disk_irq_out,
  output logic [3:0] printer_irq_out,
  output logic [3:0] disk_dma_req,
  output logic [3:0] disk_owner_lamp,
  output logic [3:0] printer_owner_lamp,
  output logic disk_cs,
  output logic [1:0] disk_addr,
  output logic disk_rd,
  output logic disk_wr,
  output logic [7:0] disk_wdata,
  input wire logic [7:0] disk_rdata,
  input wire logic disk_irq_in,
  input wire logic disk_drq_in,
  output logic printer_data_cs,
  output logic printer_ctrl_cs,
  output logic printer_rd,
  output logic printer_wr,
  output logic [7:0] printer_wdata,
  input wire logic [7:0] printer_rdata,
  input wire logic printer_irq_in,
  output logic [1:0] drive_select_out,
  output logic [1:0] motor_on,
  output logic density_select,
  output logic precomp_en,
  input wire logic drive_ready_in,
  output logic fdc_ready,
  input wire logic wd_pulse_in,
  input wire logic wd_early_in,
  input wire logic wd_late_in,
  output logic drive_wd_out
);

  localparam int PC = `SDPA_PRECOMP_CYC;
  localparam int WDW = 2 * PC + 1;

  // ========================================================================
  // Decode helpers
  // ========================================================================
  // Exact device number inside the window
  function automatic logic sdpa_hit(sdpa_addr_s a, logic [9:0] ofs);
    return a.window && (a.addr == ofs[7:1]);
  endfunction

  // Any of the four disk controller registers
  function automatic logic sdpa_disk_hit(sdpa_addr_s a);
    logic [9:0] b;
    b = `SDPA_OFS_DISK_STATUS;
    return a.window && (a.addr[6:2] == b[7:3]);
  endfunction

  // One-hot owner to port number
  function automatic logic [1:0] sdpa_idx(logic [3:0] oh);
    logic [1:0] i;
    i = 2'h0;
    for (int k = 0; k < `SDPA_PORTS; k++)
      if (oh[k])
        i = 2'(k);
    return i;
  endfunction

  // ========================================================================
  // Address phase and strobe edges
  // ========================================================================
  sdpa_addr_s [3:0] lat;
  logic [3:0] wr_q;
  logic [3:0] wr_edge;

  // Claim and drive control writes act once, on the rising write strobe
  assign wr_edge = link_write_strobe & ~wr_q;

  // Latch select and A1-A7; a host reset forgets the address
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      lat <= '0;
    else
      for (int p = 0; p < `SDPA_PORTS; p++)
      begin
        if (host_reset[p])
          lat[p] <= '0; // RULE7
        else if (link_addr_latch_strobe[p])
        begin
          lat[p].window <= !peripheral_select_n[p]; // RULE23
          lat[p].addr <= host_link_bus_in[p][7:1]; // RULE5 RULE6
        end
      end
  end

  // Previous write strobe level
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      wr_q <= '0;
    else
      wr_q <= link_write_strobe & ~host_reset;
  end

  // ========================================================================
  // Claim flags
  // ========================================================================
  logic [1:0][3:0] claim; // RULE1

  // Host reset has priority; set and clear use different numbers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      claim <= '0; // RULE9
    else
      for (int p = 0; p < `SDPA_PORTS; p++)
      begin
        if (host_reset[p])
        begin
          claim[`SDPA_RES_DISK][p] <= 1'b0; // RULE9
          claim[`SDPA_RES_PRN][p] <= 1'b0;
        end
        else if (wr_edge[p])
        begin
          if (sdpa_hit(lat[p], `SDPA_OFS_DISK_SET))
            claim[`SDPA_RES_DISK][p] <= 1'b1; // RULE10
          if (sdpa_hit(lat[p], `SDPA_OFS_DISK_CLR))
            claim[`SDPA_RES_DISK][p] <= 1'b0; // RULE10 RULE3
          if (sdpa_hit(lat[p], `SDPA_OFS_PRN_SET))
            claim[`SDPA_RES_PRN][p] <= 1'b1; // RULE11
          if (sdpa_hit(lat[p], `SDPA_OFS_PRN_CLR))
            claim[`SDPA_RES_PRN][p] <= 1'b0; // RULE11 RULE3
        end
      end
  end

  // ========================================================================
  // Scanning arbiters, one per resource
  // ========================================================================
  wire [1:0][3:0] ring_w;
  wire [1:0][3:0] grant_now;

  for (genvar r = 0; r < 2; r++)
  begin : g_arb
    logic [3:0] ring;

    // Stop on a set flag, else rotate one port a clock
    always_ff @(posedge mclk or negedge resetn)
    begin
      if (!resetn)
        ring <= `SDPA_RING_RST;
      else if (!(|(ring & claim[r]))) // RULE16 RULE17 RULE3
        ring <= {ring[2:0], ring[3]}; // RULE24 RULE15
    end

    assign ring_w[r] = ring;
    assign grant_now[r] = ring & claim[r]; // RULE2 RULE16
  end

  // Owner lamps double as bus driver enables
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      disk_owner_lamp <= '0;
      printer_owner_lamp <= '0;
    end
    else
    begin
      disk_owner_lamp <= grant_now[`SDPA_RES_DISK]; // RULE4
      printer_owner_lamp <= grant_now[`SDPA_RES_PRN]; // RULE4
    end
  end

  // ========================================================================
  // Resource buses, routed from the owner only
  // ========================================================================
  logic [1:0] d_i;
  logic [1:0] p_i;
  logic d_any;
  logic p_any;
  logic d_reg;
  logic p_reg;

  assign d_i = sdpa_idx(disk_owner_lamp);
  assign p_i = sdpa_idx(printer_owner_lamp);
  assign d_any = |disk_owner_lamp;
  assign p_any = |printer_owner_lamp;
  assign d_reg = d_any && sdpa_disk_hit(lat[d_i]); // RULE18
  assign p_reg = p_any && (sdpa_hit(lat[p_i], `SDPA_OFS_PRN_DATA) ||
                           sdpa_hit(lat[p_i], `SDPA_OFS_PRN_CTRL));

  // Disk controller strobes pass through for one cycle of latency
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      disk_cs <= 1'b0;
      disk_addr <= 2'h0;
      disk_rd <= 1'b0;
      disk_wr <= 1'b0;
      disk_wdata <= 8'h00;
    end
    else
    begin
      disk_cs <= d_reg; // RULE14
      disk_addr <= lat[d_i].addr[1:0]; // RULE18
      disk_rd <= d_reg && link_read_strobe[d_i];
      disk_wr <= d_reg && link_write_strobe[d_i];
      disk_wdata <= host_link_bus_in[d_i];
    end
  end

  // Printer strobes; registers behind them live elsewhere
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      printer_data_cs <= 1'b0;
      printer_ctrl_cs <= 1'b0;
      printer_rd <= 1'b0;
      printer_wr <= 1'b0;
      printer_wdata <= 8'h00;
    end
    else
    begin
      printer_data_cs <= p_any && sdpa_hit(lat[p_i], `SDPA_OFS_PRN_DATA); // RULE14
      printer_ctrl_cs <= p_any && sdpa_hit(lat[p_i], `SDPA_OFS_PRN_CTRL);
      printer_rd <= p_reg && link_read_strobe[p_i];
      printer_wr <= p_reg && link_write_strobe[p_i];
      printer_wdata <= host_link_bus_in[p_i];
    end
  end

  // ========================================================================
  // Host read data and returned signals
  // ========================================================================
  // Only status reads and register reads by the resource owner drive the bus
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      host_link_bus_out <= '0;
      host_link_bus_oe <= '0;
    end
    else
      for (int p = 0; p < `SDPA_PORTS; p++)
      begin
        host_link_bus_out[p] <= 8'h00;
        host_link_bus_oe[p] <= 1'b0;
        if (link_read_strobe[p] && !host_reset[p])
        begin
          if (sdpa_hit(lat[p], `SDPA_OFS_DISK_SET))
          begin
            host_link_bus_out[p][`SDPA_STAT_BIT] <= !disk_owner_lamp[p]; // RULE12
            host_link_bus_oe[p] <= 1'b1;
          end
          else if (sdpa_hit(lat[p], `SDPA_OFS_PRN_SET))
          begin
            host_link_bus_out[p][`SDPA_STAT_BIT] <= !printer_owner_lamp[p]; // RULE13
            host_link_bus_oe[p] <= 1'b1;
          end
          else if (disk_owner_lamp[p] && sdpa_disk_hit(lat[p]))
          begin
            host_link_bus_out[p] <= disk_rdata; // RULE14 RULE18
            host_link_bus_oe[p] <= 1'b1;
          end
          else if (printer_owner_lamp[p] && p_reg && (p_i == 2'(p)))
          begin
            host_link_bus_out[p] <= printer_rdata; // RULE14
            host_link_bus_oe[p] <= 1'b1;
          end
        end
      end
  end

  // Requests reach only the port that owns the resource
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      disk_irq_out <= '0;
      printer_irq_out <= '0;
      disk_dma_req <= '0;
    end
    else
    begin
      disk_irq_out <= disk_owner_lamp & {4{disk_irq_in}}; // RULE8
      printer_irq_out <= printer_owner_lamp & {4{printer_irq_in}}; // RULE8
      disk_dma_req <= disk_owner_lamp & {4{disk_drq_in}}; // RULE8
    end
  end

  // ========================================================================
  // Drive control register
  // ========================================================================
  sdpa_drvctl_s drvctl;

  // Written only by the disk owner
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      drvctl <= `SDPA_DRVCTL_RST;
    else if (d_any && wr_edge[d_i] && sdpa_hit(lat[d_i], `SDPA_OFS_DRIVE_CTRL))
      drvctl <= host_link_bus_in[d_i]; // RULE18
  end

  // Drive lines; a drive with its motor off is never selected
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      drive_select_out <= 2'h0;
      motor_on <= 2'h0;
      density_select <= 1'b0;
      precomp_en <= 1'b0;
      fdc_ready <= 1'b0;
    end
    else
    begin
      drive_select_out[0] <= !drvctl.drive_sel && drvctl.motor0; // RULE19
      drive_select_out[1] <= drvctl.drive_sel && drvctl.motor1; // RULE19
      motor_on <= {drvctl.motor1, drvctl.motor0}; // RULE20
      density_select <= drvctl.density_select; // RULE22
      precomp_en <= drvctl.precomp_en; // RULE21
      fdc_ready <= drvctl.ready_override || (drive_ready_in && // RULE22
                   (drvctl.drive_sel ? drvctl.motor1 : drvctl.motor0)); // RULE19
    end
  end

  // ========================================================================
  // Write precompensation
  // ========================================================================
  logic [WDW-1:0] wd_line;
  logic [WDW-1:0] next_wd_line;

  // Nominal pulses sit one shift late so early ones can lead them
  always_comb
  begin
    next_wd_line = {1'b0, wd_line[WDW-1:1]};
    if (wd_pulse_in)
    begin
      if (drvctl.precomp_en && wd_early_in)
        next_wd_line[0] = 1'b1; // RULE21
      else if (drvctl.precomp_en && wd_late_in)
        next_wd_line[2*PC] = 1'b1;
      else
        next_wd_line[PC] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wd_line <= '0;
      drive_wd_out <= 1'b0;
    end
    else
    begin
      wd_line <= next_wd_line;
      drive_wd_out <= wd_line[0];
    end
  end

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  wire d_set0 = wr_edge[0] && !host_reset[0] && sdpa_hit(lat[0], `SDPA_OFS_DISK_SET);
  wire d_st0 = link_read_strobe[0] && !host_reset[0] && sdpa_hit(lat[0], `SDPA_OFS_DISK_SET);

  AST_DISK_ONE_OWNER: assert property ($onehot0(disk_owner_lamp)) // RULE2
    else $error("disk granted to more than one port");
  AST_PRN_ONE_OWNER: assert property ($onehot0(printer_owner_lamp)) // RULE15
    else $error("printer granted to more than one port");
  AST_LAMP_FOLLOWS: assert property (1'b1 |=> disk_owner_lamp == $past(grant_now[0])) // RULE4
    else $error("disk lamp does not follow grant");
  AST_HOLD: assert property ((|grant_now[1]) && $stable(claim[1]) |=> $stable(ring_w[1])) // RULE17
    else $error("printer arbiter moved while holding");
  AST_SCAN: assert property (!(|grant_now[0]) |=> // RULE24
    ring_w[0] == {$past(ring_w[0][2:0]), $past(ring_w[0][3])})
    else $error("disk arbiter failed to advance");
  AST_SET_FLAG: assert property (d_set0 |=> claim[0][0]) // RULE10
    else $error("disk claim not set");
  AST_HOST_RST: assert property (host_reset[2] |=> !claim[0][2] && !claim[1][2]) // RULE9
    else $error("host reset left a claim");
  AST_STATUS: assert property (d_st0 |=> host_link_bus_oe[0] && // RULE12
    host_link_bus_out[0][7] == !$past(disk_owner_lamp[0]))
    else $error("disk status bit wrong");
  AST_IRQ_GATE: assert property (disk_irq_out[1] |-> $past(disk_owner_lamp[1]) && $past(disk_irq_in)) // RULE8
    else $error("disk irq to non-owner");
  AST_DSEL: assert property (drive_select_out[0] |-> // RULE19
    $past(drvctl.motor0) && !$past(drvctl.drive_sel))
    else $error("drive 0 selected with motor off");
  AST_GRANT_WAIT: assert property ((|claim[0]) && !(|disk_owner_lamp) |-> // RULE16
    ##[1:6] (|disk_owner_lamp))
    else $error("disk claim not served");

  COV_DISK_GRANT: cover property (d_set0 ##[1:8] disk_owner_lamp[0]);
  COV_HANDOVER: cover property (disk_owner_lamp[0] ##[1:20] disk_owner_lamp[1]);
  COV_PRN_GRANT: cover property (|printer_owner_lamp);
  COV_DRV_WRITE: cover property (disk_wr ##1 disk_rd);

endmodule // sdpa_arbiter

// ---- test/sdpa_host_model.sv ----
`timescale 1ns/100ps
// ==========================================================================
// Four host computers on their multiplexed links
// ==========================================================================
module sdpa_host_model
  import sdpa_pkg::*;
(
  input wire logic mclk,
  output logic [3:0][7:0] link_bus,
  output logic [3:0] addr_strobe,
  output logic [3:0] select_n,
  output logic [3:0] rd_strobe,
  output logic [3:0] wr_strobe,
  input wire logic [3:0][7:0] bus_back,
  input wire logic [3:0] bus_back_oe
);
  // Idle links: no strobes, select off, bus at a non-zero pattern
  initial
  begin
    link_bus = {4{8'h5A}};
    addr_strobe = 4'h0;
    select_n = 4'hF;
    rd_strobe = 4'h0;
    wr_strobe = 4'h0;
  end

  // Address phase, one clock with the latch strobe high
  task automatic latch_addr(input int p, input logic [9:0] addr, input logic sel_n);
    @(negedge mclk);
    addr_strobe[p] = 1'b1;
    select_n[p] = sel_n;
    link_bus[p] = addr[7:0];
    @(negedge mclk);
    addr_strobe[p] = 1'b0;
    select_n[p] = 1'b1;
  endtask

  // Output instruction; also how a host raises or drops its claims
  task automatic io_write(input int p, input logic [9:0] addr, input logic [7:0] data,
                          input logic sel_n);
    latch_addr(p, addr, sel_n);
    link_bus[p] = data;
    wr_strobe[p] = 1'b1;
    @(negedge mclk);
    wr_strobe[p] = 1'b0;
    link_bus[p] = ~data; // Released bus must not keep the old value
    @(negedge mclk); // Strobe low one cycle before the next access
  endtask

  // Input instruction; data taken while the read strobe still stands
  task automatic io_read(input int p, input logic [9:0] addr, output logic [7:0] data,
                         output logic oe);
    latch_addr(p, addr, 1'b0);
    link_bus[p] = ~addr[7:0];
    rd_strobe[p] = 1'b1;
    repeat (2) @(negedge mclk);
    data = bus_back[p];
    oe = bus_back_oe[p];
    rd_strobe[p] = 1'b0;
    @(negedge mclk);
  endtask
endmodule // sdpa_host_model

// ---- test/shared_disk_printer_arbiter_tb_top.sv ----
`timescale 1ns/100ps
module shared_disk_printer_arbiter_tb_top
  import sdpa_pkg::*;
;
  // ========================================================================
  // Signals
  // ========================================================================
  logic mclk, resetn, disk_irq_in, disk_drq_in, printer_irq_in, drive_ready_in;
  logic [3:0] host_reset, strobe, sel_n, rd, wr, oe, lamp_d, lamp_p, irq_d, irq_p, dma;
  logic [3:0][7:0] bus_in, bus_out;
  logic [7:0] disk_rdata, printer_rdata;
  logic [1:0] drive_select_out, motor_on;
  logic density_select, precomp_en, fdc_ready;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] ctl_vals [4] = '{8'h01, 8'h81, 8'h05, 8'h2A};
  sdpa_drvctl_s dc;
  logic exp_rdy;
  logic d_cs, d_rd, d_wr, p_dcs, p_ccs, p_rd, p_wr, wd_p, wd_e, wd_l, wd_out;
  logic [1:0] d_addr;
  logic [7:0] d_wd, p_wd, dwd, pwd;
  logic [7:0] dlog = 8'h00;
  logic [7:0] plog = 8'h00;
  localparam int PREC = 15; // 150 ns shift at the 10 ns clock

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  sdpa_host_model u_host (.mclk(mclk), .link_bus(bus_in), .addr_strobe(strobe),
    .select_n(sel_n), .rd_strobe(rd), .wr_strobe(wr), .bus_back(bus_out), .bus_back_oe(oe));

  sdpa_arbiter dut (.mclk(mclk), .resetn(resetn), .host_reset(host_reset),
    .host_link_bus_in(bus_in), .host_link_bus_out(bus_out), .host_link_bus_oe(oe),
    .link_addr_latch_strobe(strobe), .peripheral_select_n(sel_n), .link_read_strobe(rd),
    .link_write_strobe(wr), .disk_irq_out(irq_d), .printer_irq_out(irq_p),
    .disk_dma_req(dma), .disk_owner_lamp(lamp_d), .printer_owner_lamp(lamp_p),
    .disk_cs(d_cs), .disk_addr(d_addr), .disk_rd(d_rd), .disk_wr(d_wr), .disk_wdata(d_wd),
    .disk_rdata(disk_rdata), .disk_irq_in(disk_irq_in), .disk_drq_in(disk_drq_in),
    .printer_data_cs(p_dcs), .printer_ctrl_cs(p_ccs), .printer_rd(p_rd), .printer_wr(p_wr),
    .printer_wdata(p_wd), .printer_rdata(printer_rdata), .printer_irq_in(printer_irq_in),
    .drive_select_out(drive_select_out), .motor_on(motor_on),
    .density_select(density_select), .precomp_en(precomp_en),
    .drive_ready_in(drive_ready_in), .fdc_ready(fdc_ready), .wd_pulse_in(wd_p),
    .wd_early_in(wd_e), .wd_late_in(wd_l), .drive_wd_out(wd_out));

  // ========================================================================
  // Checking and closing
  // ========================================================================
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Last strobe cycle toward each controller, kept for routing checks
  always @(negedge mclk)
  begin
    if (d_rd || d_wr)
    begin
      dlog <= {3'h0, d_cs, d_rd, d_wr, d_addr};
      dwd <= d_wd;
    end
    if (p_rd || p_wr)
    begin
      plog <= {4'h0, p_dcs, p_ccs, p_rd, p_wr};
      pwd <= p_wd;
    end
  end

  // Hang guard; the full sequence needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  // Bounded wait for the owner lamps, since scan position is not known
  task automatic wait_lamp(input logic is_disk, input logic [3:0] exp);
    int i;
    for (i = 0; i < 20; i++)
    begin
      if ((is_disk ? lamp_d : lamp_p) === exp)
        break;
      @(negedge mclk);
    end
    check({4'h0, is_disk ? lamp_d : lamp_p}, {4'h0, exp});
  endtask

  // Read with a check on drive enable and, when driven, on the data
  task automatic rd_chk(input int p, input logic [9:0] addr, input logic [7:0] exp,
                        input logic exp_oe);
    logic [7:0] data;
    logic got_oe;
    u_host.io_read(p, addr, data, got_oe);
    check({7'h0, got_oe}, {7'h0, exp_oe});
    if (exp_oe)
      check(data, exp);
  endtask

  // Cycles from a write pulse to the drive line, bounded
  task automatic wd_delay(input logic early, input logic late, input int exp);
    int n;
    @(negedge mclk);
    wd_p = 1'b1;
    wd_e = early;
    wd_l = late;
    for (n = 1; n < 40; n++)
    begin
      @(negedge mclk);
      wd_p = 1'b0;
      if (wd_out === 1'b1)
        break;
    end
    check(8'(n), 8'(exp));
  endtask

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial
  begin
    resetn = 1'b0;
    host_reset = 4'h0;
    disk_rdata = 8'hA5;
    printer_rdata = 8'h3C;
    disk_irq_in = 1'b0;
    disk_drq_in = 1'b0;
    printer_irq_in = 1'b0;
    drive_ready_in = 1'b1;
    wd_p = 1'b0;
    wd_e = 1'b0;
    wd_l = 1'b0;
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    check({lamp_d, lamp_p}, 8'h00);
    // Free disk goes to the first claimant
    u_host.io_write(0, 10'h28E, 8'h00, 1'b0);
    wait_lamp(1'b1, 4'h1);
    rd_chk(0, 10'h28E, 8'h00, 1'b1);
    disk_irq_in = 1'b1;
    disk_drq_in = 1'b1;
    repeat (3) @(negedge mclk);
    check({irq_d, dma}, 8'h11);
    // Second claimant waits while the grant holds
    u_host.io_write(1, 10'h28E, 8'h00, 1'b0);
    repeat (8) @(negedge mclk);
    check({4'h0, lamp_d}, 8'h01);
    rd_chk(1, 10'h28E, 8'h80, 1'b1);
    rd_chk(1, 10'h282, 8'h00, 1'b0);
    check(dlog, 8'h00);
    rd_chk(0, 10'h282, 8'hA5, 1'b1);
    u_host.io_write(1, 10'h284, 8'hC3, 1'b0);
    check(dlog, 8'h19);
    u_host.io_write(0, 10'h284, 8'h3B, 1'b0);
    check(dlog, 8'h16);
    check(dwd, 8'h3B);
    // Drive control fields from the owner
    foreach (ctl_vals[i])
    begin
      u_host.io_write(0, 10'h288, ctl_vals[i], 1'b0);
      repeat (3) @(negedge mclk);
      dc = ctl_vals[i];
      exp_rdy = dc.ready_override | (drive_ready_in & (dc.drive_sel ? dc.motor1 : dc.motor0));
      check({6'h0, drive_select_out}, {6'h0, dc.drive_sel & dc.motor1,
            ~dc.drive_sel & dc.motor0});
      check({6'h0, motor_on}, {6'h0, dc.motor1, dc.motor0});
      check({5'h0, density_select, precomp_en, fdc_ready},
            {5'h0, dc.density_select, dc.precomp_en, exp_rdy});
    end
    // Non-owner write to drive control is ignored
    u_host.io_write(1, 10'h288, 8'hFF, 1'b0);
    repeat (3) @(negedge mclk);
    check({6'h0, motor_on}, 8'h01);
    // Precompensation still on: early, nominal and late write pulses
    wd_delay(1'b1, 1'b0, 2);
    wd_delay(1'b0, 1'b0, 2 + PREC);
    wd_delay(1'b0, 1'b1, 2 + 2 * PREC);
    // Release hands the disk on to the waiting port
    u_host.io_write(0, 10'h290, 8'h00, 1'b0);
    wait_lamp(1'b1, 4'h2);
    repeat (2) @(negedge mclk);
    check({irq_d, dma}, 8'h22);
    // Printer arbiter runs on its own
    u_host.io_write(2, 10'h292, 8'h00, 1'b0);
    wait_lamp(1'b0, 4'h4);
    u_host.io_write(3, 10'h292, 8'h00, 1'b0);
    rd_chk(3, 10'h292, 8'h80, 1'b1);
    rd_chk(2, 10'h292, 8'h00, 1'b1);
    rd_chk(2, 10'h28A, 8'h3C, 1'b1);
    rd_chk(3, 10'h28A, 8'h00, 1'b0);
    u_host.io_write(3, 10'h28C, 8'h11, 1'b0);
    check(plog, 8'h0A);
    u_host.io_write(2, 10'h28C, 8'h96, 1'b0);
    check(plog, 8'h05);
    check(pwd, 8'h96);
    printer_irq_in = 1'b1;
    repeat (3) @(negedge mclk);
    check({4'h0, irq_p}, 8'h04);
    u_host.io_write(2, 10'h294, 8'h00, 1'b0);
    wait_lamp(1'b0, 4'h8);
    check({4'h0, lamp_d}, 8'h02);
    // Host reset drops that port's claim
    host_reset[1] = 1'b1;
    repeat (2) @(negedge mclk);
    host_reset[1] = 1'b0;
    wait_lamp(1'b1, 4'h0);
    rd_chk(1, 10'h28E, 8'h80, 1'b1);
    // Claim with the window select inactive is ignored
    u_host.io_write(3, 10'h28E, 8'h00, 1'b1);
    repeat (10) @(negedge mclk);
    check({4'h0, lamp_d}, 8'h00);
    // Unit reset in mid-run drops every claim
    resetn = 1'b0;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    repeat (8) @(negedge mclk);
    check({lamp_d, lamp_p}, 8'h00);
    end_of_test();
  end
endmodule // shared_disk_printer_arbiter_tb_top
